// >>> src/adcacc_top.sv
// Converter configuration, sequencing and result accumulator.
// Assumes SFR bus pulses on core_clk and a sampled comparator code.
//
// Notes on behaviour
// (RULE1) Conversion clock is source over divider plus one
// (RULE2) Source is core clock, or oscillator in burst
// (RULE3) Bit two selects eight or ten bits
// (RULE4) Normal track converts right after start
// (RULE5) Delayed track waits three conversion clocks
// (RULE6) Gain bit selects half or unity gain
// (RULE7) Non-burst: latest result or running sum
// (RULE8) Software zeroes both result bytes first
// (RULE9) Accumulate enable and top bit read zero
// (RULE10) Format field shifts or left justifies reads
// (RULE11) Repeat field sets conversions per burst
// (RULE12) Software keeps repeat zero outside burst
// (RULE13) Complete flag after conversion or whole burst
// (RULE14) Eight-bit mode: two clocks shorter, zero LSBs
// (RULE15) Sum stored raw, formatting only on read
`timescale 1ns/1ps
`default_nettype none
module adcacc_top #(
  parameter int CONV_CLKS = adcacc_pkg::CONV_SAR_CLKS_10BIT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire adcacc_pkg::adcacc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata_q,
  input wire logic converter_enable,
  input wire logic burst_operation_enable,
  input wire logic conversion_start,
  input wire logic lp_osc_tick,
  input wire logic [9:0] sample_code,
  input wire logic flag_clear,
  output logic conversion_complete_flag,
  output logic input_gain_select,
  output logic reduced_resolution_enable,
  output logic tracking,
  output logic busy
);
  import adcacc_pkg::*;

  adcacc_conv_setup_t conv_q;
  adcacc_conv_setup_t conv_d;
  adcacc_acc_setup_t acc_q;
  adcacc_acc_setup_t acc_d;
  adcacc_state_t state_q;
  adcacc_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [6:0] rem_q;
  logic [6:0] rem_d;
  logic first_q;
  logic first_d;
  logic [15:0] sum_q;
  logic [15:0] sum_d;
  logic flag_q;
  logic flag_d;
  logic [7:0] rdata_d;
  logic sar_tick;
  logic src_tick;
  logic conv_done;
  logic start_ok;
  logic [3:0] conv_len;
  logic [15:0] code_w;
  logic [15:0] fmt_w;

  // Oscillator ticks stand in for the 20 MHz source in burst
  assign src_tick = burst_operation_enable ? lp_osc_tick : 1'b1; // see (RULE2)

  adcacc_clk_div #(.W(5)) u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .src_tick(src_tick),
    .div_value(conv_q.sar_clock_divider), // see (RULE1)
    .sar_tick_q(sar_tick)
  );

  // Eight-bit mode saves two conversion clocks
  assign conv_len = conv_q.reduced_resolution_enable ? // see (RULE14)
    4'(CONV_CLKS - EIGHT_BIT_SAVING - 1) : 4'(CONV_CLKS - 1); // see (RULE3)
  assign code_w = conv_q.reduced_resolution_enable ?
    {6'h00, sample_code[9:2], 2'h0} : {6'h00, sample_code}; // see (RULE14)
  assign conv_done = (state_q == ST_CONV) && sar_tick && (cnt_q == 4'h0);
  assign start_ok = (state_q == ST_IDLE) && conversion_start && converter_enable;

  // Read-path formatting leaves the stored sum alone
  always_comb begin
    unique case (acc_q.result_shift_justify) // see (RULE10) (RULE15)
      3'h0, 3'h1, 3'h2, 3'h3: fmt_w = sum_q >> acc_q.result_shift_justify;
      SJ_LEFT: fmt_w = sum_q << LEFT_JUSTIFY_SHIFT;
      default: fmt_w = sum_q;
    endcase
  end

  // Register file
  always_comb begin
    conv_d = conv_q;
    acc_d = acc_q;
    rdata_d = sfr_rdata_q;
    if (sfr_req.wr && sfr_req.addr == ADDR_CONV_SETUP) begin
      conv_d = adcacc_conv_setup_t'(sfr_req.wdata);
    end
    if (sfr_req.wr && sfr_req.addr == ADDR_ACC_SETUP) begin
      acc_d = adcacc_acc_setup_t'(sfr_req.wdata & 8'h7F);
    end
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        ADDR_CONV_SETUP: rdata_d = conv_q;
        ADDR_ACC_SETUP: rdata_d = acc_q & ACC_SETUP_READ_MASK; // see (RULE9)
        ADDR_RESULT_HIGH: rdata_d = fmt_w[15:8];
        ADDR_RESULT_LOW: rdata_d = fmt_w[7:0];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Sequencer and accumulator
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    rem_d = rem_q;
    first_d = first_q;
    sum_d = sum_q;
    flag_d = flag_q && !flag_clear;
    // Software byte writes clear or preset the sum
    if (sfr_req.wr && sfr_req.addr == ADDR_RESULT_HIGH) begin
      sum_d[15:8] = sfr_req.wdata; // see (RULE8)
    end
    if (sfr_req.wr && sfr_req.addr == ADDR_RESULT_LOW) begin
      sum_d[7:0] = sfr_req.wdata; // see (RULE8)
    end
    unique case (state_q)
      ST_IDLE: begin
        if (start_ok) begin
          // Repeat field assumed zero outside burst
          rem_d = burst_operation_enable ? // see (RULE11) (RULE12)
            adcacc_repeat_total(acc_q.burst_repeat_count) - 7'h01 : 7'h00;
          first_d = 1'b1;
          if (conv_q.delayed_track_select) begin
            state_d = ST_TRACK; // see (RULE5)
            cnt_d = 4'(TRACK_SAR_CLKS - 1);
          end else begin
            state_d = ST_CONV; // see (RULE4)
            cnt_d = conv_len;
          end
        end
      end
      ST_TRACK: begin
        if (sar_tick) begin
          if (cnt_q == 4'h0) begin
            state_d = ST_CONV;
            cnt_d = conv_len;
          end else begin
            cnt_d = cnt_q - 4'h1;
          end
        end
      end
      ST_CONV: begin
        if (sar_tick) begin
          cnt_d = cnt_q - 4'h1;
        end
        if (conv_done) begin
          // Conversion result wins over a same-cycle byte write
          if (burst_operation_enable) begin
            sum_d = first_q ? code_w : sum_q + code_w; // see (RULE11)
          end else begin
            sum_d = acc_q.accumulate_enable ? sum_q + code_w : code_w; // see (RULE7)
          end
          first_d = 1'b0;
          if (rem_q == 7'h00) begin
            state_d = ST_IDLE;
            flag_d = 1'b1; // see (RULE13)
          end else begin
            rem_d = rem_q - 7'h01;
            state_d = conv_q.delayed_track_select ? ST_TRACK : ST_CONV;
            cnt_d = conv_q.delayed_track_select ? 4'(TRACK_SAR_CLKS - 1) : conv_len;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_q <= adcacc_conv_setup_t'(RST_CONV_SETUP);
      acc_q <= adcacc_acc_setup_t'(RST_ACC_SETUP);
      sfr_rdata_q <= 8'h00;
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      rem_q <= 7'h00;
      first_q <= 1'b0;
      sum_q <= 16'h0000;
      flag_q <= 1'b0;
      tracking <= 1'b1;
      busy <= 1'b0;
    end else begin
      conv_q <= conv_d;
      acc_q <= acc_d;
      sfr_rdata_q <= rdata_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      rem_q <= rem_d;
      first_q <= first_d;
      sum_q <= sum_d;
      flag_q <= flag_d;
      tracking <= (state_d != ST_CONV);
      busy <= (state_d != ST_IDLE);
    end
  end

  assign conversion_complete_flag = flag_q;
  assign input_gain_select = conv_q.input_gain_select; // see (RULE6)
  assign reduced_resolution_enable = conv_q.reduced_resolution_enable; // see (RULE3)

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  flag_on_done_a: assert property (conv_done && rem_q == 7'h00 |=> flag_q) // see (RULE13)
    else $error("complete flag not set after last conversion");
  eight_bit_lsb_a: assert property (conv_done && conv_q.reduced_resolution_enable // see (RULE14)
    && !burst_operation_enable && !acc_q.accumulate_enable |=> sum_q[1:0] == 2'h0)
    else $error("eight-bit result has nonzero low bits");
  latest_result_a: assert property (conv_done && !burst_operation_enable // see (RULE7)
    && !acc_q.accumulate_enable |=> sum_q == $past(code_w))
    else $error("result register not latest conversion");
  running_sum_a: assert property (conv_done && !burst_operation_enable // see (RULE7)
    && acc_q.accumulate_enable |=> sum_q == 16'($past(sum_q) + $past(code_w)))
    else $error("running sum not updated");
  ae_reads_zero_a: assert property (sfr_req.rd && sfr_req.addr == ADDR_ACC_SETUP // see (RULE9)
    |=> sfr_rdata_q[7:6] == 2'h0)
    else $error("write-only bits read nonzero");
  delayed_track_a: assert property (start_ok && conv_q.delayed_track_select // see (RULE5)
    |=> state_q == ST_TRACK ##1 (state_q == ST_TRACK)[*2])
    else $error("delayed track did not hold");
  normal_track_a: assert property (start_ok && !conv_q.delayed_track_select // see (RULE4)
    |=> state_q == ST_CONV)
    else $error("conversion did not start at once");
  left_justify_a: assert property (sfr_req.rd && sfr_req.addr == ADDR_RESULT_HIGH // see (RULE10)
    && acc_q.result_shift_justify == SJ_LEFT |=> sfr_rdata_q == $past(sum_q[9:2]))
    else $error("left justified read wrong");
  burst_count_a: assert property (start_ok && burst_operation_enable // see (RULE11)
    |=> rem_q == 7'($past(adcacc_repeat_total(acc_q.burst_repeat_count)) - 7'h01))
    else $error("burst count not loaded");

  burst_done_c: cover property (conv_done && burst_operation_enable && rem_q == 7'h00);
  accum_c: cover property (conv_done && acc_q.accumulate_enable);
  track_c: cover property (state_q == ST_TRACK ##1 state_q == ST_CONV);
  clear_race_c: cover property (flag_clear && conv_done);

endmodule : adcacc_top
`default_nettype wire

// >>> include/adcacc_pkg.sv
// Package for the converter configuration and accumulator block.
// Assumes one core clock and an SFR-style byte bus from the core.
package adcacc_pkg;

  // SFR addresses
  localparam logic [7:0] ADDR_ACC_SETUP = 8'hBA;
  localparam logic [7:0] ADDR_CONV_SETUP = 8'hBC;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hBD;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBE;

  // Reset values
  localparam logic [7:0] RST_CONV_SETUP = 8'hF8;
  localparam logic [7:0] RST_ACC_SETUP = 8'h00;

  // Read masks: accumulate enable and the reserved top bit read as zero
  localparam logic [7:0] ACC_SETUP_READ_MASK = 8'h3F;

  // Timing in conversion clocks
  localparam int TRACK_SAR_CLKS = 3;
  localparam int CONV_SAR_CLKS_10BIT = 11;
  localparam int EIGHT_BIT_SAVING = 2;

  // Divider source rates
  localparam int CORE_CLK_MHZ = 10;
  localparam int LP_OSC_MHZ = 20;

  // Left-justify shift for a 10-bit value in 16 bits
  localparam int LEFT_JUSTIFY_SHIFT = 6;
  localparam logic [2:0] SJ_LEFT = 3'h4;

  typedef struct packed {
    logic [4:0] sar_clock_divider;
    logic reduced_resolution_enable;
    logic delayed_track_select;
    logic input_gain_select;
  } adcacc_conv_setup_t;

  typedef struct packed {
    logic reserved;
    logic accumulate_enable;
    logic [2:0] result_shift_justify;
    logic [2:0] burst_repeat_count;
  } adcacc_acc_setup_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } adcacc_sfr_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} adcacc_state_t;

  // Conversions per burst; reserved codes fall back to one
  function automatic logic [6:0] adcacc_repeat_total(input logic [2:0] code);
    case (code)
      3'h1: adcacc_repeat_total = 7'h04;
      3'h2: adcacc_repeat_total = 7'h08;
      3'h3: adcacc_repeat_total = 7'h10;
      3'h4: adcacc_repeat_total = 7'h20;
      3'h5: adcacc_repeat_total = 7'h40;
      default: adcacc_repeat_total = 7'h01;
    endcase
  endfunction : adcacc_repeat_total

endpackage : adcacc_pkg

// >>> src/adcacc_clk_div.sv
// Conversion clock divider producing a one-cycle enable.
// Assumes src_tick marks each source clock period on core_clk.
`timescale 1ns/1ps
`default_nettype none
module adcacc_clk_div #(
  parameter int W = 5
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic src_tick,
  input wire logic [W-1:0] div_value,
  output logic sar_tick_q
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick_d;

  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (src_tick) begin
      if (cnt_q >= div_value) begin // see (RULE1)
        cnt_d = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      sar_tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sar_tick_q <= tick_d;
    end
  end

  // Spacing of ticks follows divider plus one
  tick_gap_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see (RULE1)
    sar_tick_q && div_value == '0 && src_tick |=> sar_tick_q)
    else $error("divider tick missing at divide by one");

endmodule : adcacc_clk_div
`default_nettype wire

// >>> tb/test_adc_config_accumulator.sv
// Testbench for the converter configuration and accumulator block.
// Assumes the byte register bus of adcacc_top and one 10 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module test_adc_config_accumulator;
  import adcacc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  adcacc_sfr_req_t req = '0;
  logic [7:0] rdata;
  logic en = 1'b1;
  logic burst = 1'b0;
  logic start = 1'b0;
  logic osc_run = 1'b0;
  logic [9:0] code = 10'h000;
  logic fclr = 1'b0;
  logic flag, gain, reduced, tracking, busy;
  logic [7:0] b;
  logic [15:0] res;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int d0, d1;
  // Reserved repeat codes fall back to a single conversion
  int reps[8] = '{1, 4, 8, 16, 32, 64, 1, 1};
  logic trk = 1'b0;

  always #50 core_clk = ~core_clk;

  adcacc_top u_adcacc_top (.core_clk(core_clk), .rst_n(rst_n), .sfr_req(req),
    .sfr_rdata_q(rdata), .converter_enable(en), .burst_operation_enable(burst),
    .conversion_start(start), .lp_osc_tick(osc_run), .sample_code(code),
    .flag_clear(fclr), .conversion_complete_flag(flag), .input_gain_select(gain),
    .reduced_resolution_enable(reduced), .tracking(tracking), .busy(busy));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge core_clk);
    req.wr = 1'b0;
  endtask : wr

  // Read data is registered, so it is taken one full cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge core_clk);
    req.rd = 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : rd

  task automatic rd_res(output logic [15:0] v);
    logic [7:0] h, l;
    rd(ADDR_RESULT_HIGH, h);
    rd(ADDR_RESULT_LOW, l);
    v = {h, l};
  endtask : rd_res

  // Bounded wait keeps a stuck sequencer from hanging the run
  task automatic conv(input logic [9:0] c, input logic go, output int dur);
    code = c;
    dur = 0;
    if (go) begin
      @(negedge core_clk);
      start = 1'b1;
      @(negedge core_clk);
      start = 1'b0;
      chk({busy, tracking}, {1'b1, trk});
    end
    while (flag !== 1'b1 && dur < 3000) begin
      @(negedge core_clk);
      dur++;
    end
    chk(flag, 1'b1);
    fclr = 1'b1;
    @(negedge core_clk);
    fclr = 1'b0;
    @(negedge core_clk);
    chk({flag, busy, tracking}, 3'b001);
  endtask : conv

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    chk({flag, busy, tracking, reduced, gain}, 5'b00100);
    rd(ADDR_CONV_SETUP, b);
    chk(b, RST_CONV_SETUP);
    rd(ADDR_ACC_SETUP, b);
    chk(b, RST_ACC_SETUP);
    chk({reduced, gain}, 2'b00);
    rd(8'h00, b);
    chk(b, 8'h00);
    wr(ADDR_CONV_SETUP, 8'h07);
    rd(ADDR_CONV_SETUP, b);
    chk(b, 8'h07);
    chk({reduced, gain}, 2'b11);
    wr(ADDR_ACC_SETUP, 8'hFF);
    rd(ADDR_ACC_SETUP, b);
    chk(b, 8'h3F);
    wr(ADDR_ACC_SETUP, 8'h00);
    wr(ADDR_CONV_SETUP, 8'h00);
    conv(10'h155, 1'b1, d0);
    rd_res(res);
    chk(res, 16'h0155);
    conv(10'h0AA, 1'b1, d1);
    rd_res(res);
    chk(res, 16'h00AA);
    wr(ADDR_CONV_SETUP, 8'h02);
    trk = 1'b1;
    conv(10'h0AA, 1'b1, d1);
    trk = 1'b0;
    chk(16'(d1 - d0), 16'h0003);
    wr(ADDR_CONV_SETUP, 8'h04);
    conv(10'h3FF, 1'b1, d1);
    chk(16'(d0 - d1), 16'h0002);
    rd_res(res);
    chk(res, 16'h03FC);
    // Divider phase at start is not pinned, so one cycle of slack either way
    wr(ADDR_CONV_SETUP, 8'h08);
    conv(10'h001, 1'b1, d1);
    chk(d1 >= d0 + 10 && d1 <= d0 + 12, 1'b1);
    wr(ADDR_CONV_SETUP, 8'h00);
    wr(ADDR_ACC_SETUP, 8'h40);
    wr(ADDR_RESULT_HIGH, 8'h00);
    wr(ADDR_RESULT_LOW, 8'h00);
    conv(10'h100, 1'b1, d1);
    conv(10'h100, 1'b1, d1);
    // Reserved format codes read the stored sum as it is
    for (int s = 0; s < 6; s++) begin
      wr(ADDR_ACC_SETUP, 8'h40 | 8'(s << 3));
      rd_res(res);
      chk(res, s < 4 ? 16'h0200 >> s : (s == 4 ? 16'h8000 : 16'h0200));
    end
    wr(ADDR_ACC_SETUP, 8'h40);
    rd_res(res);
    chk(res, 16'h0200);
    wr(ADDR_ACC_SETUP, 8'h00);
    en = 1'b0;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(busy, 1'b0);
    en = 1'b1;
    // Oscillator held still: burst must not advance on the core clock
    burst = 1'b1;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    repeat (40) @(negedge core_clk);
    chk(flag, 1'b0);
    osc_run = 1'b1;
    conv(10'h010, 1'b0, d1);
    for (int r = 0; r < 8; r++) begin
      wr(ADDR_ACC_SETUP, 8'(r));
      conv(10'h010, 1'b1, d1);
      rd_res(res);
      chk(res, 16'(reps[r] * 16));
    end
    wr(ADDR_ACC_SETUP, 8'h00);
    burst = 1'b0;
    print_verdict();
  end
endmodule : test_adc_config_accumulator
`default_nettype wire
